// *** inc/lfcp_pkg.sv ***
// Shared constants and carrier types for the loop-back, link-fault and configuration block.
// Assumes a single 20 MHz clock and an AXI4-Lite register port with 32-bit data.
package lfcp_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int LFCP_NCH = 4;
    localparam int LFCP_ADDR_W = 8;
    localparam int LFCP_NLATCH = 16;
    localparam int LFCP_NIRQ = 5;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] LFCP_CTRL_OFF = 8'h00;
    localparam logic [7:0] LFCP_STAT_OFF = 8'h04;
    localparam logic [7:0] LFCP_IRQ_STAT_OFF = 8'h08;
    localparam logic [7:0] LFCP_IRQ_MASK_OFF = 8'h0C;
    localparam logic [7:0] LFCP_LATCH_BASE = 8'h40;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int LFCP_CTRL_LOOP_LSB = 0;
    localparam int LFCP_CTRL_LCF_LSB = 4;
    localparam int LFCP_STAT_LF_LSB = 0;
    localparam int LFCP_STAT_TRK_LSB = 4;
    localparam int LFCP_IRQ_CFG_BIT = 4;
    localparam logic [3:0] LFCP_LOOP_RST = 4'h0;
    localparam logic [3:0] LFCP_LCF_RST = 4'hF;
    localparam logic [4:0] LFCP_MASK_RST = 5'h00;
    localparam logic [3:0] LFCP_OE_LATCH = 4'hB;
    localparam logic [7:0] LFCP_CFG_INIT [LFCP_NLATCH] = '{default: 8'h00};

    // ------------------------------------------------------------------
    // AXI responses
    // ------------------------------------------------------------------
    localparam logic [1:0] LFCP_RESP_OKAY = 2'h0;
    localparam logic [1:0] LFCP_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rate_bad;
        logic amp_low;
        logic density_low;
        logic rx_disabled;
        logic ref_missing;
    } lfcp_fault_t;

    typedef struct packed {
        logic cfg_write_strobe_n;
        logic [3:0] addr;
        logic [7:0] data;
    } lfcp_cfg_port_t;

endpackage : lfcp_pkg

// *** verilog/lfcp_cfg_latches.sv ***
// Configuration latch bank written from the host configuration pins.
// Assumes the pins are synchronous to aclk and held stable around the strobe's rising edge.
`timescale 1ns/1ps
module lfcp_cfg_latches
    import lfcp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire lfcp_cfg_port_t cfg_port,
    output logic [LFCP_NLATCH-1:0][7:0] latch_q,
    output logic wr_pulse
);

    logic strobe_prev_reg;
    logic capture;

    assign capture = !strobe_prev_reg && cfg_port.cfg_write_strobe_n;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            strobe_prev_reg <= 1'b1;
        else
            strobe_prev_reg <= cfg_port.cfg_write_strobe_n;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wr_pulse <= 1'b0;
        else
            wr_pulse <= capture;
    end

    // Each latch loads its value on the low-to-high return of the strobe.
    for (genvar i = 0; i < LFCP_NLATCH; i++)
    begin : g_latch
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
                latch_q[i] <= LFCP_CFG_INIT[i];
            else if (capture && cfg_port.addr == 4'(i))
                latch_q[i] <= cfg_port.data;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    cfg_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
        capture |=> latch_q[$past(cfg_port.addr)] == $past(cfg_port.data))
        else $error("addressed latch did not take the data");

    strobe_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!strobe_prev_reg && !cfg_port.cfg_write_strobe_n) |=> $stable(latch_q))
        else $error("latch changed while strobe held low");

    reset_init_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> latch_q[0] == LFCP_CFG_INIT[0]
            && latch_q[LFCP_OE_LATCH] == LFCP_CFG_INIT[LFCP_OE_LATCH])
        else $error("latch not at initial value after reset");

endmodule : lfcp_cfg_latches

// *** verilog/lfcp_channel.sv ***
// One channel's loop-back routing, driver forcing, recovery tracking and link-fault output.
// Assumes serial streams are sampled on aclk as plain synchronous levels.
`timescale 1ns/1ps
module lfcp_channel
    import lfcp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic serial_loop_select,
    input wire logic local_clock_force,
    input wire logic [1:0] drv_en,
    input wire logic tx_serial,
    input wire logic rx_serial,
    input wire lfcp_fault_t fault,
    output logic [1:0] serial_out,
    output logic cdr_data,
    output logic track_ref,
    output logic link_fault_n
);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            serial_out <= 2'h0;
        else if (serial_loop_select)
            serial_out <= drv_en;
        else
            serial_out <= drv_en & {2{tx_serial}};
    end

    // The recovery input takes the own transmit stream in loop-back, never the pins.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cdr_data <= 1'b0;
        else
            cdr_data <= serial_loop_select ? tx_serial : rx_serial;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            track_ref <= 1'b1;
        else
            track_ref <= !local_clock_force;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            link_fault_n <= 1'b0;
        else
            link_fault_n <= !((|fault) || !local_clock_force);
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    loop_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        serial_loop_select |=> cdr_data == $past(tx_serial))
        else $error("loop-back did not route transmit stream");

    driver_force_a: assert property (@(posedge aclk) disable iff (!aresetn)
        serial_loop_select |=> serial_out == $past(drv_en))
        else $error("enabled drivers not forced high in loop-back");

    input_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (serial_loop_select && rx_serial != tx_serial) |=> cdr_data != $past(rx_serial))
        else $error("serial input reached recovery in loop-back");

    normal_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !serial_loop_select |=> cdr_data == $past(rx_serial)
            && serial_out == ($past(drv_en) & {2{$past(tx_serial)}}))
        else $error("normal path wrong without loop-back");

    fault_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ((|fault) || !local_clock_force) |=> !link_fault_n)
        else $error("fault indicator not low under a fault");

    fault_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (fault == '0 && local_clock_force) |=> link_fault_n)
        else $error("fault indicator low without any fault");

    ref_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !local_clock_force |=> track_ref)
        else $error("recovery loop not tracking reference");

endmodule : lfcp_channel

// *** verilog/lfcp_top.sv ***
// Top of the loop-back, link-fault and configuration block with its AXI4-Lite register port.
// Assumes one 20 MHz clock, synchronous active-low reset and pins synchronous to aclk.
//
// Operation
// - Loop-back routes a channel's transmit stream into its own receive recovery.
// - In loop-back every enabled serial driver of the channel sits at logic one.
// - In loop-back the channel's external serial inputs are ignored by recovery.
// - Without loop-back the normal transmit and receive paths apply.
// - Each channel drives an active-low link-fault output, an OR of six conditions.
// - Fault: bad rate, low amplitude, low density, rx disabled, clock force, no reference.
// - Host gives address and data, pulses strobe; addressed latch stores the data.
// - Reset loads every configuration latch with its initial value.
// - While local clock force is low, recovery tracks the channel reference clock.
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module lfcp_top
    import lfcp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [LFCP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [LFCP_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire lfcp_cfg_port_t cfg_port,
    input wire logic [LFCP_NCH-1:0] tx_serial,
    input wire logic [LFCP_NCH-1:0] rx_serial,
    input wire lfcp_fault_t [LFCP_NCH-1:0] ch_fault,
    output logic [LFCP_NCH-1:0][1:0] serial_out,
    output logic [LFCP_NCH-1:0] cdr_data,
    output logic [LFCP_NCH-1:0] track_ref,
    output logic [LFCP_NCH-1:0] link_fault_n,
    output logic [LFCP_NLATCH-1:0][7:0] cfg_latch,
    output logic irq
);

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [LFCP_NCH-1:0] loop_reg;
    logic [LFCP_NCH-1:0] lcf_reg;
    logic [LFCP_NIRQ-1:0] irq_stat_reg;
    logic [LFCP_NIRQ-1:0] irq_mask_reg;
    logic [LFCP_NCH-1:0] lf_prev_reg;
    logic [LFCP_NIRQ-1:0] irq_event;
    logic cfg_wr_pulse;

    // ------------------------------------------------------------------
    // AXI write channel state
    // ------------------------------------------------------------------
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [LFCP_ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_do;
    logic wr_hit;
    logic wr_lane0;

    assign wr_do = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    assign wr_lane0 = w_strb_reg[0];

    always_comb
    begin
        unique case (aw_addr_reg)
            LFCP_CTRL_OFF, LFCP_IRQ_STAT_OFF, LFCP_IRQ_MASK_OFF: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end
        else if (wr_do)
            aw_hold_reg <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_hold_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end
        else if (wr_do)
            w_hold_reg <= 1'b0;
    end

    // Ready falls on acceptance and returns when the response is taken.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_awready <= 1'b1;
        else if (s_axi_awvalid && s_axi_awready)
            s_axi_awready <= 1'b0;
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_awready <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_wready <= 1'b1;
        else if (s_axi_wvalid && s_axi_wready)
            s_axi_wready <= 1'b0;
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_wready <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= LFCP_RESP_OKAY;
        end
        else if (wr_do)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? LFCP_RESP_OKAY : LFCP_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            loop_reg <= LFCP_LOOP_RST;
            lcf_reg <= LFCP_LCF_RST;
        end
        else if (wr_do && wr_lane0 && aw_addr_reg == LFCP_CTRL_OFF)
        begin
            loop_reg <= w_data_reg[LFCP_CTRL_LOOP_LSB +: LFCP_NCH];
            lcf_reg <= w_data_reg[LFCP_CTRL_LCF_LSB +: LFCP_NCH];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_mask_reg <= LFCP_MASK_RST;
        else if (wr_do && wr_lane0 && aw_addr_reg == LFCP_IRQ_MASK_OFF)
            irq_mask_reg <= w_data_reg[LFCP_NIRQ-1:0];
    end

    // A new event in the clearing cycle survives the write of one.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_stat_reg <= '0;
        else if (wr_do && wr_lane0 && aw_addr_reg == LFCP_IRQ_STAT_OFF)
            irq_stat_reg <= (irq_stat_reg & ~w_data_reg[LFCP_NIRQ-1:0]) | irq_event;
        else
            irq_stat_reg <= irq_stat_reg | irq_event;
    end

    always_ff @(posedge aclk)
    begin
        // Starts at the reset level of the fault outputs, so leaving reset is no event.
        if (!aresetn)
            lf_prev_reg <= '0;
        else
            lf_prev_reg <= link_fault_n;
    end

    assign irq_event = {cfg_wr_pulse, lf_prev_reg & ~link_fault_n};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_reg & irq_mask_reg);
    end

    // ------------------------------------------------------------------
    // AXI read channel
    // ------------------------------------------------------------------
    logic [31:0] rd_word;
    logic rd_hit;
    logic [3:0] rd_latch_idx;

    assign rd_latch_idx = s_axi_araddr[5:2];

    always_comb
    begin
        rd_word = '0;
        rd_hit = 1'b1;
        if (s_axi_araddr[7:6] == LFCP_LATCH_BASE[7:6] && s_axi_araddr[1:0] == 2'h0)
            rd_word[7:0] = cfg_latch[rd_latch_idx];
        else
        begin
            unique case (s_axi_araddr)
                LFCP_CTRL_OFF:
                begin
                    rd_word[LFCP_CTRL_LOOP_LSB +: LFCP_NCH] = loop_reg;
                    rd_word[LFCP_CTRL_LCF_LSB +: LFCP_NCH] = lcf_reg;
                end
                LFCP_STAT_OFF:
                begin
                    rd_word[LFCP_STAT_LF_LSB +: LFCP_NCH] = link_fault_n;
                    rd_word[LFCP_STAT_TRK_LSB +: LFCP_NCH] = track_ref;
                end
                LFCP_IRQ_STAT_OFF: rd_word[LFCP_NIRQ-1:0] = irq_stat_reg;
                LFCP_IRQ_MASK_OFF: rd_word[LFCP_NIRQ-1:0] = irq_mask_reg;
                default: rd_hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_arready <= 1'b1;
        else if (s_axi_arvalid && s_axi_arready)
            s_axi_arready <= 1'b0;
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_arready <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= LFCP_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? LFCP_RESP_OKAY : LFCP_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Configuration latches and channels
    // ------------------------------------------------------------------
    lfcp_cfg_latches u_latches (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg_port(cfg_port),
        .latch_q(cfg_latch),
        .wr_pulse(cfg_wr_pulse)
    );

    // The driver enable latch holds two enables per channel, lower pair for channel zero.
    for (genvar c = 0; c < LFCP_NCH; c++)
    begin : g_ch
        lfcp_channel u_ch (
            .aclk(aclk),
            .aresetn(aresetn),
            .serial_loop_select(loop_reg[c]),
            .local_clock_force(lcf_reg[c]),
            .drv_en(cfg_latch[LFCP_OE_LATCH][2*c +: 2]),
            .tx_serial(tx_serial[c]),
            .rx_serial(rx_serial[c]),
            .fault(ch_fault[c]),
            .serial_out(serial_out[c]),
            .cdr_data(cdr_data[c]),
            .track_ref(track_ref[c]),
            .link_fault_n(link_fault_n[c])
        );
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    loop_ctrl_a: assert property (@(posedge aclk) disable iff (!aresetn)
        loop_reg[0] |=> cdr_data[0] == $past(tx_serial[0]))
        else $error("loop-back control did not steer channel zero");

    fault_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (lf_prev_reg[0] && !link_fault_n[0]) |=> irq_stat_reg[0])
        else $error("link fault event not recorded");

    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        |(irq_stat_reg & irq_mask_reg) |=> irq)
        else $error("interrupt not raised for unmasked status");

endmodule : lfcp_top

// *** verif/lfcp_cfg_host.sv ***
// Host model that writes the configuration latches through the configuration pins.
// Assumes aclk is the block's clock and the pins are sampled on its rising edge.
`timescale 1ns/1ps
module lfcp_cfg_host
    import lfcp_pkg::*;
(
    input wire logic aclk,
    output lfcp_cfg_port_t cfg_port
);
    // Idle pins sit at the pull-up level, so the strobe is high.
    initial cfg_port = '{1'b1, 4'hF, 8'hFF};

    task put(input logic [3:0] a, input logic [7:0] d, input int lo);
        @(posedge aclk);
        cfg_port <= '{1'b0, a, d};
        repeat (lo) @(posedge aclk);
        cfg_port.cfg_write_strobe_n <= 1'b1;
        @(posedge aclk);
        cfg_port <= '{1'b1, 4'hF, 8'hFF};
    endtask : put
endmodule : lfcp_cfg_host

// *** verif/lfcp_top_bench.sv ***
// Self-checking bench for the loop-back, link-fault and configuration block.
// Assumes the host model drives the configuration pins and AXI4-Lite reaches the registers.
`timescale 1ns/1ps
module lfcp_top_bench;
    import lfcp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awa = 8'h00;
    logic [7:0] ara = 8'h00;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] ws = 4'hF;
    logic awr, wr, bv, arr, rv, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rd, v;
    lfcp_cfg_port_t cfg_port;
    logic [3:0] tx = 4'h0, rx = 4'h0, cdr, trk, lfn;
    lfcp_fault_t [3:0] flt = '0;
    logic [3:0][1:0] sout;
    logic [15:0][7:0] latch;
    logic [7:0] oe = 8'h9C;
    int failures = 0;
    int n_checks = 0;

    initial forever #25 aclk = ~aclk;

    lfcp_top lfcp_top_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .cfg_port(cfg_port), .tx_serial(tx), .rx_serial(rx), .ch_fault(flt),
        .serial_out(sout), .cdr_data(cdr), .track_ref(trk), .link_fault_n(lfn),
        .cfg_latch(latch), .irq(irq)
    );

    lfcp_cfg_host lfcp_cfg_host_inst (
        .aclk(aclk),
        .cfg_port(cfg_port)
    );

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end
        while (!bv);
        r = bresp;
        br <= 1'b0;
        chk(r, er);
    endtask : axw

    task axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end
        while (!rv);
        v = rd;
        r = rresp;
        rr <= 1'b0;
        chk(v, exp);
        chk(r, er);
    endtask : axr

    task results;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        tick(10);
        aresetn <= 1'b1;
        tick(2);
        for (int i = 0; i < 16; i++) chk(latch[i], LFCP_CFG_INIT[i]);
        axr(LFCP_CTRL_OFF, {24'h0, LFCP_LCF_RST, LFCP_LOOP_RST}, LFCP_RESP_OKAY);
        axr(LFCP_STAT_OFF, 32'h0F, LFCP_RESP_OKAY);
        ws <= 4'hE;
        axw(LFCP_CTRL_OFF, 32'h0F, LFCP_RESP_OKAY);
        ws <= 4'hF;
        axr(LFCP_CTRL_OFF, 32'hF0, LFCP_RESP_OKAY);
        axr(8'h20, 32'h0, LFCP_RESP_SLVERR);
        axw(LFCP_STAT_OFF, 32'h1, LFCP_RESP_SLVERR);
        lfcp_cfg_host_inst.put(LFCP_OE_LATCH, oe, 1);
        tick(2);
        chk(latch[11], oe);
        axr(LFCP_LATCH_BASE + 8'd44, {24'h0, oe}, LFCP_RESP_OKAY);
        axr(LFCP_IRQ_STAT_OFF, 32'h10, LFCP_RESP_OKAY);
        axw(LFCP_IRQ_MASK_OFF, 32'h10, LFCP_RESP_OKAY);
        tick(2);
        chk(irq, 1'b1);
        axw(LFCP_IRQ_STAT_OFF, 32'h10, LFCP_RESP_OKAY);
        tick(2);
        chk(irq, 1'b0);
        lfcp_cfg_host_inst.put(4'h3, 8'hA5, 4);
        tick(3);
        chk(latch[3], 8'hA5);
        chk(latch[11], oe);
        chk(irq, 1'b1);
        axw(LFCP_IRQ_MASK_OFF, 32'h0, LFCP_RESP_OKAY);
        tick(2);
        chk(irq, 1'b0);
        for (int c = 0; c < 4; c++)
        begin
            axw(LFCP_CTRL_OFF, 32'hF0 | (32'h1 << c), LFCP_RESP_OKAY);
            for (int p = 0; p < 2; p++)
            begin
                tx <= p ? 4'h5 : 4'hA;
                rx <= p ? 4'hA : 4'h5;
                tick(3);
                for (int i = 0; i < 4; i++)
                begin
                    chk(cdr[i], (i == c) ? tx[i] : rx[i]);
                    chk(sout[i], oe[2*i +: 2] & ((i == c) ? 2'b11 : {2{tx[i]}}));
                end
            end
        end
        axw(LFCP_CTRL_OFF, 32'hF0, LFCP_RESP_OKAY);
        for (int c = 0; c < 4; c++)
        begin
            for (int k = 0; k < 5; k++)
            begin
                flt[c] <= lfcp_fault_t'(5'h01 << k);
                tick(3);
                chk(lfn, 4'hF & ~(4'h1 << c));
                flt <= '0;
                tick(3);
                chk(lfn, 4'hF);
            end
        end
        axr(LFCP_IRQ_STAT_OFF, 32'h1F, LFCP_RESP_OKAY);
        axw(LFCP_IRQ_MASK_OFF, 32'h0F, LFCP_RESP_OKAY);
        tick(2);
        chk(irq, 1'b1);
        axw(LFCP_IRQ_STAT_OFF, 32'h1F, LFCP_RESP_OKAY);
        tick(2);
        chk(irq, 1'b0);
        axw(LFCP_CTRL_OFF, 32'h00, LFCP_RESP_OKAY);
        tick(3);
        chk(lfn, 4'h0);
        chk(trk, 4'hF);
        axr(LFCP_STAT_OFF, 32'hF0, LFCP_RESP_OKAY);
        axw(LFCP_CTRL_OFF, 32'hF0, LFCP_RESP_OKAY);
        tick(3);
        chk(trk, 4'h0);
        aresetn <= 1'b0;
        tick(10);
        aresetn <= 1'b1;
        tick(2);
        chk(latch[3], LFCP_CFG_INIT[3]);
        chk(latch[11], LFCP_CFG_INIT[11]);
        results;
    end

    initial
    begin
        tick(5000);
        failures++;
        results;
    end
endmodule : lfcp_top_bench
